// ---- src/pps_selector.sv ----
// power path selector control: switch sequencing, protection, status
`timescale 1ns/10ps
`default_nettype none
`include "pps_defines.svh"

module pps_selector #(
    parameter int unsigned DETECT_CYCLES =
        int'((64'(`PPS_DETECT_DELAY_MS) * 64'(`PPS_CLK_HZ)) / 64'd1000),
    parameter int unsigned LOWPACK_CYCLES =
        int'((64'(`PPS_LOWPACK_DEGLITCH_MS) * 64'(`PPS_CLK_HZ)) / 64'd1000),
    parameter int unsigned OC_DEGLITCH_CYCLES =
        int'((64'(`PPS_OC_DEGLITCH_US) * 64'(`PPS_CLK_HZ)) / 64'd1000000),
    parameter int unsigned OC_RETRY_CYCLES =
        int'((64'(`PPS_OC_RETRY_MS) * 64'(`PPS_CLK_HZ)) / 64'd1000)
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // register word port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // comparators, high when true
    input wire logic adapter_detect_input,
    input wire logic load_rail_near_pack,
    input wire logic pack_below_depleted,
    input wire logic input_overcurrent,
    input wire logic adapter_near_pack,
    input wire logic adapter_above_pack,
    // switch state feedback, high when off
    input wire logic adapter_path_switch_off,
    input wire logic pack_path_switch_off,
    // switch drives, high turns switch on
    output logic adapter_switch_drive,
    output logic pack_switch_drive,
    output logic bypass_switch_drive,
    // thresholds for the analog comparators
    output logic [15:0] pack_depleted_threshold_mv,
    output logic [15:0] overcurrent_level_ma,
    // open-drain alarm, enable low while pulling low
    output logic alarm_out,
    output logic alarm_oe_n
);

    // ----------------------------------------------------------------
    // threshold arithmetic
    // ----------------------------------------------------------------
    function automatic logic [15:0] dep_mv(input logic [2:0] sel, input logic [15:0] volt);
        logic [15:0] per_cell;
        logic [15:0] cells;
        per_cell = `PPS_DEP_BASE_MV + 16'(sel * `PPS_DEP_STEP_MV);
        cells = (volt >= `PPS_FOUR_CELL_MV) ? 16'h0004 : 16'h0003;
        dep_mv = 16'(per_cell * cells);
    endfunction

    function automatic logic [15:0] oc_ma(input logic [1:0] sel, input logic [15:0] limit);
        logic [7:0] pct;
        logic [23:0] prod;
        pct = `PPS_OC_BASE_PCT + 8'(sel * `PPS_OC_STEP_PCT);
        prod = 24'(limit * pct);
        oc_ma = 16'(prod / 24'h000064);
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] mode_q;
    logic [15:0] volt_q;
    logic [15:0] curr_q;
    logic [15:0] status_word;
    logic status_read;
    logic learn_q;
    logic oc_en;
    logic [1:0] oc_sel;
    logic [2:0] dep_sel;

    assign learn_q = mode_q[`PPS_MODE_LEARN_BIT];
    assign oc_en = mode_q[`PPS_MODE_OC_EN_BIT];
    assign oc_sel = mode_q[`PPS_MODE_OC_LVL_LSB +: 2];
    assign dep_sel = mode_q[`PPS_MODE_DEP_LSB +: 3];

    pps_regs u_regs (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .status_word(status_word),
        .mode_q(mode_q),
        .volt_q(volt_q),
        .curr_q(curr_q),
        .status_read(status_read)
    );

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    logic detect_done;
    logic lowpack_done;
    logic oc_done;
    logic retry_done;
    logic lowpack_watch;
    logic oc_watch;
    logic oc_off_q;
    logic lowpack_done_q;
    logic oc_done_q;
    pps_pkg::pps_state_t state_q;

    // delay restarts on every detect drop
    pps_qualify #(.LIMIT(DETECT_CYCLES)) u_detect (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .level(adapter_detect_input),
        .done(detect_done)
    );

    assign lowpack_watch = pack_switch_drive && pack_below_depleted;
    pps_qualify #(.LIMIT(LOWPACK_CYCLES)) u_lowpack (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .level(lowpack_watch),
        .done(lowpack_done)
    );

    assign oc_watch = oc_en && adapter_switch_drive && input_overcurrent;
    pps_qualify #(.LIMIT(OC_DEGLITCH_CYCLES)) u_oc (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .level(oc_watch),
        .done(oc_done)
    );

    pps_qualify #(.LIMIT(OC_RETRY_CYCLES)) u_retry (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .level(oc_off_q),
        .done(retry_done)
    );

    // ----------------------------------------------------------------
    // event edges
    // ----------------------------------------------------------------
    logic dep_event;
    logic oc_event;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lowpack_done_q <= 1'b0;
            oc_done_q <= 1'b0;
        end else if (ce) begin
            lowpack_done_q <= lowpack_done;
            oc_done_q <= oc_done;
        end
    end

    assign dep_event = lowpack_done && !lowpack_done_q;
    assign oc_event = oc_done && !oc_done_q;

    // ----------------------------------------------------------------
    // overcurrent off time
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oc_off_q <= 1'b0;
        end else if (ce) begin
            if (!detect_done || retry_done) begin
                oc_off_q <= 1'b0;
            end else if (oc_event) begin
                oc_off_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // depleted lockout
    // ----------------------------------------------------------------
    // keeps the pack off after a depleted event, otherwise the
    // selector would reconnect it at once and chatter
    logic dep_lock_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dep_lock_q <= 1'b0;
        end else if (ce) begin
            if (dep_event) begin
                dep_lock_q <= 1'b1;
            end else if (!learn_q && (detect_done || !pack_below_depleted)) begin
                dep_lock_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // selector sequence
    // ----------------------------------------------------------------
    logic want_adapter;

    assign want_adapter = (detect_done && !learn_q) || dep_lock_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= pps_pkg::PPS_ST_TO_PACK;
        end else if (ce) begin
            case (state_q)
                pps_pkg::PPS_ST_PACK: begin
                    if (want_adapter) begin
                        state_q <= pps_pkg::PPS_ST_TO_ADAPT;
                    end
                end
                pps_pkg::PPS_ST_TO_ADAPT: begin
                    if (!want_adapter) begin
                        state_q <= pps_pkg::PPS_ST_TO_PACK;
                    end else if (pack_path_switch_off) begin
                        state_q <= pps_pkg::PPS_ST_ADAPT;
                    end
                end
                pps_pkg::PPS_ST_ADAPT: begin
                    if (!want_adapter) begin
                        state_q <= pps_pkg::PPS_ST_TO_PACK;
                    end
                end
                pps_pkg::PPS_ST_TO_PACK: begin
                    if (want_adapter) begin
                        state_q <= pps_pkg::PPS_ST_TO_ADAPT;
                    end else if (adapter_path_switch_off && load_rail_near_pack) begin
                        state_q <= pps_pkg::PPS_ST_PACK;
                    end
                end
                default: state_q <= pps_pkg::PPS_ST_TO_PACK;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // switch drives
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            adapter_switch_drive <= 1'b0;
            pack_switch_drive <= 1'b0;
        end else if (ce) begin
            // drive off as soon as detect drops, not after the state moves
            adapter_switch_drive <= adapter_detect_input && detect_done && !oc_off_q &&
                (state_q == pps_pkg::PPS_ST_ADAPT) && pack_path_switch_off;
            pack_switch_drive <= (state_q == pps_pkg::PPS_ST_PACK) && !want_adapter &&
                adapter_path_switch_off && !adapter_switch_drive;
        end
    end

    // ----------------------------------------------------------------
    // bypass switch
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bypass_switch_drive <= 1'b0;
        end else if (ce) begin
            if (!adapter_detect_input || !detect_done) begin
                bypass_switch_drive <= 1'b0;
            end else if (adapter_near_pack) begin
                bypass_switch_drive <= 1'b0;
            end else if (adapter_above_pack) begin
                bypass_switch_drive <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // thresholds
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pack_depleted_threshold_mv <= 16'h0000;
            overcurrent_level_ma <= 16'h0000;
        end else if (ce) begin
            pack_depleted_threshold_mv <= dep_mv(dep_sel, volt_q);
            overcurrent_level_ma <= oc_ma(oc_sel, curr_q);
        end
    end

    // ----------------------------------------------------------------
    // status and alarm
    // ----------------------------------------------------------------
    logic pack_low_q;
    logic pack_on_q;
    logic adapt_on_q;
    logic alarm_q;
    logic conn_change;

    assign conn_change = (pack_on_q != pack_switch_drive) || (adapt_on_q != adapter_switch_drive);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pack_on_q <= 1'b0;
            adapt_on_q <= 1'b0;
        end else if (ce) begin
            pack_on_q <= pack_switch_drive;
            adapt_on_q <= adapter_switch_drive;
        end
    end

    // set wins over the clearing read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pack_low_q <= 1'b0;
            alarm_q <= 1'b0;
        end else if (ce) begin
            if (dep_event) begin
                pack_low_q <= 1'b1;
            end else if (status_read) begin
                pack_low_q <= 1'b0;
            end
            if (dep_event || conn_change) begin
                alarm_q <= 1'b1;
            end else if (status_read) begin
                alarm_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[`PPS_STAT_PACK_ON_BIT] = pack_on_q;
        status_word[`PPS_STAT_ADAPT_ON_BIT] = adapt_on_q;
        status_word[`PPS_STAT_PACK_LOW_BIT] = pack_low_q;
    end

    // open drain: pin is only ever pulled low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarm_out <= 1'b0;
            alarm_oe_n <= 1'b1;
        end else if (ce) begin
            alarm_out <= 1'b0;
            alarm_oe_n <= !alarm_q;
        end
    end

endmodule
`default_nettype wire

// ---- src/pps_defines.svh ----
// constants of the power path selector control
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define PPS_CLK_HZ 25000000
`define PPS_DETECT_DELAY_MS 500
`define PPS_LOWPACK_DEGLITCH_MS 1000
`define PPS_OC_DEGLITCH_US 200
`define PPS_OC_RETRY_MS 2
`define PPS_CNT_W 25

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PPS_ADDR_MODE 8'h12
`define PPS_ADDR_STATUS 8'h13
`define PPS_ADDR_CHG_VOLT 8'h15
`define PPS_ADDR_IN_CURR 8'h3F

// ----------------------------------------------------------------
// mode register fields and reset
// ----------------------------------------------------------------
`define PPS_MODE_RESET 16'h0001
`define PPS_MODE_LEARN_BIT 1
`define PPS_MODE_OC_EN_BIT 6
`define PPS_MODE_OC_LVL_LSB 7
`define PPS_MODE_DEP_LSB 9

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define PPS_STAT_PACK_ON_BIT 6
`define PPS_STAT_ADAPT_ON_BIT 7
`define PPS_STAT_PACK_LOW_BIT 11

// ----------------------------------------------------------------
// threshold arithmetic
// ----------------------------------------------------------------
`define PPS_DEP_BASE_MV 16'h0898
`define PPS_DEP_STEP_MV 16'h0064
`define PPS_OC_BASE_PCT 8'h82
`define PPS_OC_STEP_PCT 8'h14
`define PPS_FOUR_CELL_MV 16'h3E80
`define PPS_IN_CURR_MASK 16'h7F80

`endif

// ---- src/pps_pkg.sv ----
// types of the power path selector control
package pps_pkg;

    // gray coded selector states along the usual cycle
    typedef enum logic [1:0] {
        PPS_ST_PACK = 2'b00,
        PPS_ST_TO_ADAPT = 2'b01,
        PPS_ST_ADAPT = 2'b11,
        PPS_ST_TO_PACK = 2'b10
    } pps_state_t;

endpackage

// ---- src/pps_qualify.sv ----
// level qualifier: output rises once input held for a cycle count
`timescale 1ns/10ps
`default_nettype none
`include "pps_defines.svh"

module pps_qualify #(
    parameter int unsigned LIMIT = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // level in, qualified level out
    input wire logic level,
    output logic done
);

    localparam logic [`PPS_CNT_W-1:0] LAST = `PPS_CNT_W'(LIMIT - 1);

    logic [`PPS_CNT_W-1:0] cnt_q;

    // ----------------------------------------------------------------
    // count while held, restart on any drop
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= '0;
            done <= 1'b0;
        end else if (ce) begin
            if (!level) begin
                cnt_q <= '0;
                done <= 1'b0;
            end else if (cnt_q == LAST) begin
                done <= 1'b1;
            end else begin
                cnt_q <= cnt_q + `PPS_CNT_W'(1);
            end
        end
    end

endmodule
`default_nettype wire

// ---- src/pps_regs.sv ----
// host register file: mode, charge voltage, input current, read mux
`timescale 1ns/10ps
`default_nettype none
`include "pps_defines.svh"

module pps_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // word access from the smbus engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // register contents and status
    input wire logic [15:0] status_word,
    output logic [15:0] mode_q,
    output logic [15:0] volt_q,
    output logic [15:0] curr_q,
    output logic status_read
);

    // ----------------------------------------------------------------
    // writes
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= `PPS_MODE_RESET;
            volt_q <= 16'h0000;
            curr_q <= 16'h0000;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `PPS_ADDR_MODE: mode_q <= reg_wdata;
                `PPS_ADDR_CHG_VOLT: volt_q <= reg_wdata;
                `PPS_ADDR_IN_CURR: curr_q <= reg_wdata & `PPS_IN_CURR_MASK;
                default: mode_q <= mode_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // reads; unmapped offsets return zero
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            status_read <= 1'b0;
        end else if (ce) begin
            status_read <= reg_rd && (reg_addr == `PPS_ADDR_STATUS);
            if (reg_rd) begin
                case (reg_addr)
                    `PPS_ADDR_MODE: reg_rdata <= mode_q;
                    `PPS_ADDR_STATUS: reg_rdata <= status_word;
                    `PPS_ADDR_CHG_VOLT: reg_rdata <= volt_q;
                    `PPS_ADDR_IN_CURR: reg_rdata <= curr_q;
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ---- tb/pps_selector_properties.sv ----
// port checker for the power path selector control
`timescale 1ns/10ps
`default_nettype none
module pps_selector_properties #(
    parameter int unsigned DETECT_CYCLES = 20,
    parameter int unsigned LOWPACK_CYCLES = 30,
    parameter int unsigned OC_DEGLITCH_CYCLES = 5
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    // comparators and feedback
    input wire logic adapter_detect_input,
    input wire logic load_rail_near_pack,
    input wire logic pack_below_depleted,
    input wire logic input_overcurrent,
    input wire logic adapter_path_switch_off,
    // drives and alarm
    input wire logic adapter_switch_drive,
    input wire logic pack_switch_drive,
    input wire logic bypass_switch_drive,
    input wire logic alarm_oe_n
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ------------
    // helper logic
    // ------------
    int unsigned det_q;
    int unsigned low_q;
    int unsigned oc_q;
    logic oc_en_q;
    logic rd13;
    assign rd13 = reg_rd && reg_addr == 8'h13;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            det_q <= 0;
            low_q <= 0;
            oc_q <= 0;
        end else begin
            det_q <= adapter_detect_input ? det_q + 1 : 0;
            low_q <= (pack_switch_drive && pack_below_depleted) ? low_q + 1 : 0;
            oc_q <= (oc_en_q && adapter_switch_drive && input_overcurrent) ? oc_q + 1 : 0;
        end
    end
    // shadow of the enable bit, only host writes move it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oc_en_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h12) begin
            oc_en_q <= reg_wdata[6];
        end
    end

    // ------------
    // assertions
    // ------------
    a_adapter_off_idle: assert property (
        !adapter_detect_input |=> !adapter_switch_drive)
        else $error("adapter drive on with no adapter");
    a_bypass_off_idle: assert property (
        !adapter_detect_input |=> !bypass_switch_drive)
        else $error("bypass drive on with no adapter");
    a_never_both_on: assert property (
        !(adapter_switch_drive && pack_switch_drive))
        else $error("both path drives on");
    a_pack_on_safe: assert property (
        $rose(pack_switch_drive) |-> $past(adapter_path_switch_off) && $past(load_rail_near_pack))
        else $error("pack drive rose too early");
    a_detect_wait_done: assert property (
        $fell(pack_switch_drive) |-> det_q >= DETECT_CYCLES - 1 || low_q >= LOWPACK_CYCLES - 1)
        else $error("pack drive fell before delay");
    a_lowpack_swap: assert property (
        low_q == LOWPACK_CYCLES |-> ##[0:3] !pack_switch_drive)
        else $error("low pack not disconnected");
    a_oc_trip_off: assert property (
        oc_en_q && oc_q == OC_DEGLITCH_CYCLES |-> ##[0:3] !adapter_switch_drive)
        else $error("overcurrent did not open adapter");
    a_alarm_release: assert property (
        $rose(alarm_oe_n) |-> $past(rd13, 3))
        else $error("alarm released without status read");
    a_alarm_on_change: assert property (
        pack_switch_drive != $past(pack_switch_drive) || adapter_switch_drive != $past(adapter_switch_drive)
        |-> ##[1:5] !alarm_oe_n)
        else $error("connection change without alarm");

    c_adapter_on: cover property ($rose(adapter_switch_drive));
    c_lowpack: cover property (low_q == LOWPACK_CYCLES);
    c_alarm_ack: cover property ($rose(alarm_oe_n));
endmodule
`default_nettype wire

// ---- tb/pps_host_model.sv ----
// host controller model on the register word port
`timescale 1ns/10ps
`default_nettype none
module pps_host_model (
    // clock
    input wire logic core_clk,
    // register word port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // open-drain alarm
    input wire logic alarm_out,
    input wire logic alarm_oe_n,
    output logic alarm_pin
);
    // board pull-up wins while the pin is released
    assign alarm_pin = alarm_oe_n ? 1'b1 : alarm_out;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end
    // idle bus shows inverted values, never a stale word
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge core_clk);
        #1;
        d = reg_rdata;
    endtask
    task automatic set_mode(input logic [15:0] d);
        wr(8'h12, d);
    endtask
    task automatic ack_alarm(output logic [15:0] d);
        rd(8'h13, d);
    endtask
endmodule
`default_nettype wire

// ---- tb/pps_selector_tb_top.sv ----
// self-checking bench for the power path selector control
`timescale 1ns/10ps
`default_nettype none
module pps_selector_tb_top;
    // ------------
    // shortened counts keep the run brief
    // ------------
    localparam int DET = 20;
    localparam int LOW = 30;
    localparam int OCD = 5;
    localparam int OCR = 10;
    logic core_clk, rst, ce, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_word;
    logic adapter_detect_input, load_rail_near_pack, pack_below_depleted;
    logic input_overcurrent, adapter_near_pack, adapter_above_pack;
    logic adapter_path_switch_off, pack_path_switch_off;
    logic adapter_switch_drive, pack_switch_drive, bypass_switch_drive;
    logic [15:0] pack_depleted_threshold_mv, overcurrent_level_ma;
    logic alarm_out, alarm_oe_n, alarm_pin;
    int err_total, adapter_mv;
    int n_compared;

    pps_selector #(
        .DETECT_CYCLES(DET),
        .LOWPACK_CYCLES(LOW),
        .OC_DEGLITCH_CYCLES(OCD),
        .OC_RETRY_CYCLES(OCR)
    ) i_dut (.*);
    pps_host_model i_host (.*);
    assign adapter_near_pack = adapter_mv <= 12000 + 250;
    assign adapter_above_pack = adapter_mv > 12000 + 300;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // switches confirm off 1 ns after the drive drops, within the same clock cycle
    always @(posedge core_clk) begin
        #1;
        adapter_path_switch_off = !adapter_switch_drive;
        pack_path_switch_off = !pack_switch_drive;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic conclude;
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------
    // scenarios
    // ------------
    task automatic t_start;
        cyc(5);
        chk(pack_switch_drive, 1'b0);
        load_rail_near_pack = 1'b1;
        cyc(4);
        chk(pack_switch_drive, 1'b1);
        chk(alarm_pin, 1'b0);
        i_host.rd(8'h12, rd_word);
        chk(rd_word, 16'h0001);
        i_host.rd(8'h20, rd_word);
        chk(rd_word, 16'h0000);
        i_host.ack_alarm(rd_word);
        chk(rd_word[7:6], 2'b01);
        cyc(2);
        chk(alarm_pin, 1'b1);
    endtask
    task automatic t_thresh;
        int i;
        i_host.wr(8'h15, 16'h2EE0);
        i_host.wr(8'h3F, 16'h0800);
        for (i = 0; i < 8; i++) begin
            i_host.set_mode(16'((i << 9) | ((i % 4) << 7)));
            cyc(2);
            chk(pack_depleted_threshold_mv, 16'(3 * (2200 + 100 * i)));
            chk(overcurrent_level_ma, 16'(2048 * (130 + 20 * (i % 4)) / 100));
        end
        i_host.wr(8'h15, 16'h41A0);
        cyc(2);
        chk(pack_depleted_threshold_mv, 16'h2D50);
        i_host.set_mode(16'h0000);
    endtask
    task automatic t_adapter;
        adapter_mv = 19000;
        adapter_detect_input = 1'b1;
        cyc(DET - 3);
        chk(pack_switch_drive, 1'b1);
        chk(bypass_switch_drive, 1'b0);
        cyc(10);
        chk(pack_switch_drive, 1'b0);
        chk(adapter_switch_drive, 1'b1);
        chk(bypass_switch_drive, 1'b1);
        i_host.ack_alarm(rd_word);
        chk(rd_word[7:6], 2'b10);
        adapter_mv = 12200;
        cyc(3);
        chk(bypass_switch_drive, 1'b0);
        adapter_mv = 12280;
        cyc(3);
        chk(bypass_switch_drive, 1'b0);
        ce = 1'b0;
        adapter_mv = 12400;
        cyc(3);
        chk(bypass_switch_drive, 1'b0);
        ce = 1'b1;
        cyc(3);
        chk(bypass_switch_drive, 1'b1);
    endtask
    task automatic t_oc;
        input_overcurrent = 1'b1;
        cyc(3 * OCD);
        chk(adapter_switch_drive, 1'b1);
        input_overcurrent = 1'b0;
        i_host.set_mode(16'h0040);
        input_overcurrent = 1'b1;
        cyc(OCD - 2);
        input_overcurrent = 1'b0;
        cyc(2);
        chk(adapter_switch_drive, 1'b1);
        input_overcurrent = 1'b1;
        cyc(OCD + 3);
        chk(adapter_switch_drive, 1'b0);
        input_overcurrent = 1'b0;
        cyc(OCR - 5);
        chk(adapter_switch_drive, 1'b0);
        cyc(8);
        chk(adapter_switch_drive, 1'b1);
        i_host.set_mode(16'h0000);
    endtask
    task automatic t_learn;
        i_host.set_mode(16'h0002);
        cyc(6);
        chk(pack_switch_drive, 1'b1);
        chk(adapter_switch_drive, 1'b0);
        i_host.set_mode(16'h0000);
        cyc(8);
        chk(adapter_switch_drive, 1'b1);
        i_host.set_mode(16'h0002);
        cyc(6);
        pack_below_depleted = 1'b1;
        cyc(LOW + 8);
        chk(pack_switch_drive, 1'b0);
        chk(adapter_switch_drive, 1'b1);
        chk(alarm_pin, 1'b0);
        pack_below_depleted = 1'b0;
        i_host.ack_alarm(rd_word);
        chk(rd_word[11], 1'b1);
        i_host.ack_alarm(rd_word);
        chk(rd_word[11], 1'b0);
        i_host.set_mode(16'h0000);
    endtask
    task automatic t_remove;
        adapter_detect_input = 1'b0;
        cyc(2);
        chk(adapter_switch_drive, 1'b0);
        chk(bypass_switch_drive, 1'b0);
        cyc(5);
        chk(pack_switch_drive, 1'b1);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        conclude();
    end
    initial begin
        err_total = 0;
        n_compared = 0;
        rst = 1'b1;
        ce = 1'b1;
        adapter_detect_input = 1'b0;
        load_rail_near_pack = 1'b0;
        pack_below_depleted = 1'b0;
        input_overcurrent = 1'b0;
        adapter_mv = 0;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_start();
        t_thresh();
        t_adapter();
        t_oc();
        t_learn();
        t_remove();
        conclude();
    end
endmodule
bind pps_selector pps_selector_properties #(
    .DETECT_CYCLES(DETECT_CYCLES),
    .LOWPACK_CYCLES(LOWPACK_CYCLES),
    .OC_DEGLITCH_CYCLES(OC_DEGLITCH_CYCLES)
) i_props (.*);
`default_nettype wire
